/* design/fiap_consts.svh */
// constants for the flash programming sequencer
`ifndef FIAP_CONSTS_SVH
`define FIAP_CONSTS_SVH
// special function register offsets on the cpu side
`define FIAP_SFR_CTRL_MAIN   4'h0
`define FIAP_SFR_CTRL_AUX    4'h1
`define FIAP_SFR_ADDR_LOW    4'h2
`define FIAP_SFR_ADDR_HIGH   4'h3
`define FIAP_SFR_D0_LOW      4'h4
`define FIAP_SFR_D0_HIGH     4'h5
`define FIAP_SFR_KEY_FIRST   4'h6
`define FIAP_SFR_KEY_LAST    4'hB
// flash_control_main fields
`define FIAP_CM_ENABLED      7
`define FIAP_CM_MODE_HI      6
`define FIAP_CM_MODE_LO      4
`define FIAP_CM_TRIGGER      3
`define FIAP_CM_PROG         2
`define FIAP_CM_RDEN         1
`define FIAP_CM_RDI          0
// flash_control_aux fields
`define FIAP_CA_TSEL         1
`define FIAP_CA_BCLR         0
// flash_op_mode_sel codes
`define FIAP_MODE_WRITE      3'h0
`define FIAP_MODE_ERASE      3'h1
`define FIAP_MODE_READ       3'h3
`define FIAP_MODE_UNLOCK     3'h6
// key bytes, pairs one to three, low then high
`define FIAP_KEY1_LOW        8'h00
`define FIAP_KEY2_LOW        8'h0D
`define FIAP_KEY3_LOW        8'hC3
`define FIAP_KEY1_HIGH       8'h04
`define FIAP_KEY2_HIGH       8'h09
`define FIAP_KEY3_HIGH       8'h40
// timing
`define FIAP_CLK_NS          25
`define FIAP_T_ERASE0_NS     3200000
`define FIAP_T_WRITE0_NS     2200000
`define FIAP_T_ERASE1_NS     3700000
`define FIAP_T_WRITE1_NS     3000000
`define FIAP_READ_CYC        3
`define FIAP_UNLOCK_CYC      64
// host wishbone byte offsets
`define FIAP_WB_CMD          4'h0
`define FIAP_WB_STATUS       4'h4
`define FIAP_CMD_READ_BIT    16
`endif

/* design/fiap_pkg.sv */
// types shared by the sequencer and the cpu end
package fiap_pkg;
  typedef enum logic [2:0] {
    FIAP_IDLE, FIAP_ERASE, FIAP_PROG, FIAP_WAIT, FIAP_CLEAR, FIAP_READ
  } fiap_state_t;
  typedef enum logic [1:0] {
    FIAP_H_IDLE, FIAP_H_ISSUE, FIAP_H_WAIT
  } fiap_hstate_t;
endpackage

/* design/fiap_if.sv */
// special function register link between cpu end and sequencer
`timescale 1ns/10ps
interface fiap_if;
  logic       sfr_we;
  logic       sfr_re;
  logic [3:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       stall;
  modport cpu (output sfr_we, sfr_re, sfr_addr, sfr_wdata,
               input  sfr_rdata, stall);
  modport seq (input  sfr_we, sfr_re, sfr_addr, sfr_wdata,
               output sfr_rdata, stall);
endinterface

/* design/fiap_timer.sv */
// loadable down counter with a one-cycle done pulse
`timescale 1ns/10ps
module fiap_timer #(
  parameter int W = 18
) (
  input  wire logic         clk_i,   // system clock
  input  wire logic         rst_i,   // sync reset
  input  wire logic         start_i, // load and run
  input  wire logic [W-1:0] load_i,  // cycles, at least one
  output logic              busy_o,  // counting
  output logic              done_o   // pulse at expiry
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      cnt_q  <= load_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && cnt_q == W'(1);
      if (busy_o) begin
        cnt_q <= cnt_q - W'(1);
        if (cnt_q == W'(1)) begin
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule

/* design/fiap_seq.sv */
// flash programming sequencer: unlock, page buffer, erase, write, read
//
// Summary of operation
// - mode 110 then trigger starts unlock timer
// - low key bytes 00H 0DH C3H
// - high key bytes 04H 09H 40H
// - timer expiry clears trigger regardless of keys
// - all six keys match sets enabled flag
// - software clear of enabled disables at once
// - 32-word buffer mapped to page bits 13..5
// - low then high byte; high commits, increments
// - buffer address saturates at last page word
// - mode 001 initiate erases page, self-clears
// - mode 000 initiate programs buffer, self-clears
// - buffer clear empties buffer, then self-clears
// - cpu stalled while erase or write runs
// - initiate duration follows timing-select bit
// - erase whole page; program stays within page
// - reprogram same page after clear, no erase
// - read: mode 011, read enable, address, initiate
// - read result into pair zero, initiate clears
// - read stalls cpu four cycles
// - reads not gated by enabled flag
// - erase 3.2/3.7 ms, write 2.2/3.0 ms
// - software write of one to enabled ignored
// - dummy high writes tag erase addresses, saturating
`timescale 1ns/10ps
`include "fiap_consts.svh"
module fiap_seq
  import fiap_pkg::*;
#(
  parameter int ERASE0_CYC = `FIAP_T_ERASE0_NS / `FIAP_CLK_NS,
  parameter int WRITE0_CYC = `FIAP_T_WRITE0_NS / `FIAP_CLK_NS,
  parameter int ERASE1_CYC = `FIAP_T_ERASE1_NS / `FIAP_CLK_NS,
  parameter int WRITE1_CYC = `FIAP_T_WRITE1_NS / `FIAP_CLK_NS,
  parameter int UNLOCK_CYC = `FIAP_UNLOCK_CYC,
  parameter int WORDS      = 32
) (
  input  wire logic        clk_i,         // system clock
  input  wire logic        rst_i,         // sync reset
  fiap_if.seq              sfr,           // cpu side
  output logic             flash_erase_o, // page erase pulse
  output logic             flash_we_o,    // word program pulse
  output logic             flash_rd_o,    // word read pulse
  output logic [13:0]      flash_addr_o,  // word address
  output logic [15:0]      flash_wdata_o, // word to program
  input  wire logic [15:0] flash_rdata_i  // word read back
);
  localparam int TW = 18;

  // saturating increment of the in-page word index
  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    return (v == 5'h1F) ? v : v + 5'h01;
  endfunction

  fiap_state_t state_q;
  logic [2:0]  mode_q;
  logic        enabled_q, trig_q, prog_q, rden_q, rdi_q;
  logic        tsel_q, bclr_q, stall_q;
  logic [13:0] addr_q;
  logic [7:0]  d0l_q, d0h_q, rdata_q;
  logic [7:0]  key_q [6];
  logic [15:0] wbuf_q [WORDS];
  logic [WORDS-1:0] tag_q;
  logic [4:0]  idx_q;
  logic        op_start, op_done, unl_start, unl_done, unl_busy;
  logic [TW-1:0] op_load;
  logic        wr, wr_ctrl, wr_aux, wr_d0h;
  logic [2:0]  mode_new;
  logic        keys_ok;
  logic        go_erase, go_prog, go_read, go_clear;

  assign wr       = sfr.sfr_we && !stall_q;
  assign wr_ctrl  = wr && sfr.sfr_addr == `FIAP_SFR_CTRL_MAIN;
  assign wr_aux   = wr && sfr.sfr_addr == `FIAP_SFR_CTRL_AUX;
  assign wr_d0h   = wr && sfr.sfr_addr == `FIAP_SFR_D0_HIGH;
  assign mode_new = sfr.sfr_wdata[`FIAP_CM_MODE_HI:`FIAP_CM_MODE_LO];
  assign keys_ok  = key_q[0] == `FIAP_KEY1_LOW  &&
                    key_q[1] == `FIAP_KEY1_HIGH &&
                    key_q[2] == `FIAP_KEY2_LOW  &&
                    key_q[3] == `FIAP_KEY2_HIGH &&
                    key_q[4] == `FIAP_KEY3_LOW  &&
                    key_q[5] == `FIAP_KEY3_HIGH;
  // erase and program launches need the enable flag; reads and buffer clears do not
  assign go_erase = state_q == FIAP_IDLE && wr_ctrl && enabled_q &&
                    sfr.sfr_wdata[`FIAP_CM_PROG] &&
                    mode_new == `FIAP_MODE_ERASE;
  assign go_prog  = state_q == FIAP_IDLE && wr_ctrl && enabled_q &&
                    sfr.sfr_wdata[`FIAP_CM_PROG] &&
                    mode_new == `FIAP_MODE_WRITE;
  assign go_read  = state_q == FIAP_IDLE && wr_ctrl && rden_q &&
                    sfr.sfr_wdata[`FIAP_CM_RDI] &&
                    mode_new == `FIAP_MODE_READ;
  assign go_clear = state_q == FIAP_IDLE && wr_aux &&
                    sfr.sfr_wdata[`FIAP_CA_BCLR];
  assign unl_start = wr_ctrl && !trig_q && sfr.sfr_wdata[`FIAP_CM_TRIGGER]
                     && mode_new == `FIAP_MODE_UNLOCK;

  always_comb begin
    op_start = go_erase || go_read ||
               (state_q == FIAP_PROG && idx_q == 5'h1F);
    op_load  = TW'(`FIAP_READ_CYC);
    if (go_erase) begin
      op_load = tsel_q ? TW'(ERASE1_CYC) : TW'(ERASE0_CYC);
    end else if (state_q == FIAP_PROG) begin
      op_load = tsel_q ? TW'(WRITE1_CYC) : TW'(WRITE0_CYC);
    end
  end

  fiap_timer #(.W(TW)) u_op_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (op_start),
    .load_i  (op_load),
    .busy_o  (),
    .done_o  (op_done)
  );

  fiap_timer #(.W(TW)) u_unlock_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (unl_start),
    .load_i  (TW'(UNLOCK_CYC)),
    .busy_o  (unl_busy),
    .done_o  (unl_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q    <= 3'h0;
      enabled_q <= 1'b0;
      trig_q    <= 1'b0;
      rden_q    <= 1'b0;
      tsel_q    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_q <= mode_new;
        rden_q <= sfr.sfr_wdata[`FIAP_CM_RDEN];
      end
      if (wr_aux) begin
        tsel_q <= sfr.sfr_wdata[`FIAP_CA_TSEL];
      end
      // hardware set wins over a same-cycle software clear
      if (unl_done && keys_ok) begin
        enabled_q <= 1'b1;
      end else if (wr_ctrl && !sfr.sfr_wdata[`FIAP_CM_ENABLED]) begin
        enabled_q <= 1'b0;
      end
      if (unl_start) begin
        trig_q <= 1'b1;
      end else if (unl_done) begin
        trig_q <= 1'b0;
      end
    end
  end

  // key bytes, only while the window runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 6; i++) begin
        key_q[i] <= 8'h00;
      end
    end else if (unl_start) begin
      // stale keys from an earlier try must not unlock
      for (int i = 0; i < 6; i++) begin
        key_q[i] <= 8'hFF;
      end
    end else if (wr && unl_busy && sfr.sfr_addr >= `FIAP_SFR_KEY_FIRST &&
                 sfr.sfr_addr <= `FIAP_SFR_KEY_LAST) begin
      key_q[3'(sfr.sfr_addr - `FIAP_SFR_KEY_FIRST)] <= sfr.sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address, data pair zero and write buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= 14'h0000;
      d0l_q  <= 8'h00;
      d0h_q  <= 8'h00;
    end else begin
      if (wr && sfr.sfr_addr == `FIAP_SFR_ADDR_LOW) begin
        addr_q[7:0] <= sfr.sfr_wdata;
      end else if (wr_d0h) begin
        addr_q[4:0] <= sat_inc(addr_q[4:0]);
      end
      if (wr && sfr.sfr_addr == `FIAP_SFR_ADDR_HIGH) begin
        addr_q[13:8] <= sfr.sfr_wdata[5:0];
      end
      if (wr && sfr.sfr_addr == `FIAP_SFR_D0_LOW) begin
        d0l_q <= sfr.sfr_wdata;
      end
      if (wr_d0h) begin
        d0h_q <= sfr.sfr_wdata;
      end else if (state_q == FIAP_READ && op_done) begin
        d0h_q <= flash_rdata_i[15:8];
      end
      if (state_q == FIAP_READ && op_done) begin
        d0l_q <= flash_rdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag_q <= '0;
    end else if (state_q == FIAP_CLEAR) begin
      wbuf_q[idx_q] <= 16'h0000;
      tag_q[idx_q]  <= 1'b0;
    end else if (state_q == FIAP_ERASE && op_done) begin
      tag_q <= '0; // erase tags are used up
    end else if (wr_d0h) begin
      // commit the word at the index inside the selected page
      wbuf_q[addr_q[4:0]] <= {sfr.sfr_wdata, d0l_q};
      tag_q[addr_q[4:0]]  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= FIAP_IDLE;
      idx_q   <= 5'h00;
      prog_q  <= 1'b0;
      rdi_q   <= 1'b0;
      bclr_q  <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      case (state_q)
        FIAP_IDLE: begin
          idx_q <= 5'h00;
          if (go_erase) begin
            prog_q  <= 1'b1;
            stall_q <= 1'b1;
            state_q <= FIAP_ERASE;
          end else if (go_prog) begin
            prog_q  <= 1'b1;
            stall_q <= 1'b1;
            state_q <= FIAP_PROG;
          end else if (go_read) begin
            rdi_q   <= 1'b1;
            stall_q <= 1'b1;
            state_q <= FIAP_READ;
          end else if (go_clear) begin
            bclr_q  <= 1'b1;
            state_q <= FIAP_CLEAR;
          end
        end
        FIAP_PROG: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q == 5'h1F) begin
            state_q <= FIAP_WAIT;
          end
        end
        FIAP_ERASE, FIAP_WAIT: begin
          if (op_done) begin
            prog_q  <= 1'b0;
            stall_q <= 1'b0;
            state_q <= FIAP_IDLE;
          end
        end
        FIAP_READ: begin
          if (op_done) begin
            rdi_q   <= 1'b0;
            stall_q <= 1'b0;
            state_q <= FIAP_IDLE;
          end
        end
        FIAP_CLEAR: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q == 5'h1F) begin
            bclr_q  <= 1'b0;
            state_q <= FIAP_IDLE;
          end
        end
        default: begin
          state_q <= FIAP_IDLE;
        end
      endcase
    end
  end

  // flash strobes; program never leaves the page held in addr_q
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_erase_o <= 1'b0;
      flash_we_o    <= 1'b0;
      flash_rd_o    <= 1'b0;
      flash_addr_o  <= 14'h0000;
      flash_wdata_o <= 16'h0000;
    end else begin
      flash_erase_o <= go_erase;
      flash_rd_o    <= go_read;
      flash_we_o    <= state_q == FIAP_PROG && tag_q[idx_q];
      flash_wdata_o <= wbuf_q[idx_q];
      if (go_erase) begin
        flash_addr_o <= {addr_q[13:5], 5'h00};
      end else if (go_read) begin
        flash_addr_o <= addr_q;
      end else if (state_q == FIAP_PROG) begin
        flash_addr_o <= {addr_q[13:5], idx_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr.sfr_re) begin
      case (sfr.sfr_addr)
        `FIAP_SFR_CTRL_MAIN: rdata_q <= {enabled_q, mode_q, trig_q,
                                         prog_q, rden_q, rdi_q};
        `FIAP_SFR_CTRL_AUX:  rdata_q <= {6'h00, tsel_q, bclr_q};
        `FIAP_SFR_ADDR_LOW:  rdata_q <= addr_q[7:0];
        `FIAP_SFR_ADDR_HIGH: rdata_q <= {2'h0, addr_q[13:8]};
        `FIAP_SFR_D0_LOW:    rdata_q <= d0l_q;
        `FIAP_SFR_D0_HIGH:   rdata_q <= d0h_q;
        default: begin
          if (sfr.sfr_addr <= `FIAP_SFR_KEY_LAST) begin
            rdata_q <= key_q[3'(sfr.sfr_addr - `FIAP_SFR_KEY_FIRST)];
          end else begin
            rdata_q <= 8'h00;
          end
        end
      endcase
    end
  end

  assign sfr.sfr_rdata = rdata_q;
  assign sfr.stall     = stall_q;
endmodule

/* design/fiap_cpu.sv */
// cpu end: turns wishbone commands into register accesses
`timescale 1ns/10ps
`include "fiap_consts.svh"
module fiap_cpu
  import fiap_pkg::*;
(
  input  wire logic        clk_i,    // system clock
  input  wire logic        rst_i,    // sync reset
  input  wire logic        wb_cyc_i, // wishbone cycle
  input  wire logic        wb_stb_i, // wishbone strobe
  input  wire logic        wb_we_i,  // write
  input  wire logic [3:0]  wb_adr_i, // byte address
  input  wire logic [3:0]  wb_sel_i, // byte enables
  input  wire logic [31:0] wb_dat_i, // write data
  output logic [31:0]      wb_dat_o, // read data
  output logic             wb_ack_o, // acknowledge
  fiap_if.cpu              sfr       // sequencer side
);
  fiap_hstate_t hst_q;
  logic       we_q, re_q, is_read_q;
  logic [3:0] addr_q;
  logic [7:0] wdata_q, rdata_q;
  logic       req, cmd_wr;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a command needs all three low lanes; partial writes are dropped
  assign cmd_wr = req && wb_we_i && wb_adr_i == `FIAP_WB_CMD &&
                  wb_sel_i[2:0] == 3'h7 && hst_q == FIAP_H_IDLE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        if (wb_adr_i == `FIAP_WB_STATUS) begin
          wb_dat_o <= {16'h0000, rdata_q, 6'h00, sfr.stall,
                       hst_q != FIAP_H_IDLE};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one access at a time; the stall holds the next one back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hst_q     <= FIAP_H_IDLE;
      we_q      <= 1'b0;
      re_q      <= 1'b0;
      is_read_q <= 1'b0;
      addr_q    <= 4'h0;
      wdata_q   <= 8'h00;
      rdata_q   <= 8'h00;
    end else begin
      case (hst_q)
        FIAP_H_IDLE: begin
          if (cmd_wr) begin
            is_read_q <= wb_dat_i[`FIAP_CMD_READ_BIT];
            we_q      <= !wb_dat_i[`FIAP_CMD_READ_BIT];
            re_q      <= wb_dat_i[`FIAP_CMD_READ_BIT];
            addr_q    <= wb_dat_i[11:8];
            wdata_q   <= wb_dat_i[7:0];
            hst_q     <= FIAP_H_ISSUE;
          end
        end
        FIAP_H_ISSUE: begin
          we_q  <= 1'b0;
          re_q  <= 1'b0;
          hst_q <= FIAP_H_WAIT;
        end
        FIAP_H_WAIT: begin
          if (!sfr.stall) begin
            if (is_read_q) begin
              rdata_q <= sfr.sfr_rdata;
            end
            hst_q <= FIAP_H_IDLE;
          end
        end
        default: begin
          hst_q <= FIAP_H_IDLE;
        end
      endcase
    end
  end

  assign sfr.sfr_we    = we_q;
  assign sfr.sfr_re    = re_q;
  assign sfr.sfr_addr  = addr_q;
  assign sfr.sfr_wdata = wdata_q;
endmodule

/* verification/fiap_link_asserts.sv */
// assertions on the register link between the cpu end and the sequencer
`timescale 1ns/10ps
module fiap_link_asserts #(
  parameter int ERASE0_CYC = 20,
  parameter int WRITE0_CYC = 15,
  parameter int ERASE1_CYC = 30,
  parameter int WRITE1_CYC = 25,
  parameter int UNLOCK_CYC = 64
) (
  input wire logic       clk_i,     // system clock
  input wire logic       rst_i,     // sync reset
  input wire logic       sfr_we,    // register write pulse
  input wire logic       sfr_re,    // register read pulse
  input wire logic [3:0] sfr_addr,  // register offset
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic       stall      // cpu stall
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       ctl_wr;
  logic       tsel_q;
  logic       armed_q;
  logic [2:0] mode_q;
  logic [9:0] len_q;
  logic [9:0] age_q;
  int         lo;
  assign ctl_wr = sfr_we && sfr_addr == 4'h0 && !stall;
  always_ff @(posedge clk_i) begin
    if (rst_i) mode_q <= 3'h0;
    else if (ctl_wr) mode_q <= sfr_wdata[6:4];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) tsel_q <= 1'b0;
    else if (sfr_we && sfr_addr == 4'h1 && !stall) tsel_q <= sfr_wdata[1];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !stall) len_q <= 10'h000;
    else len_q <= len_q + 10'h001;
  end
  // armed: only a trigger may lead to the enabled flag reading one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      age_q   <= 10'h3FF;
    end else if (ctl_wr && sfr_wdata[6:3] == 4'hD) begin
      armed_q <= 1'b1;
      age_q   <= 10'h000;
    end else begin
      if (ctl_wr && !sfr_wdata[7]) armed_q <= 1'b0;
      if (age_q != 10'h3FF) age_q <= age_q + 10'h001;
    end
  end
  // shortest stall expected for the operation last launched
  always_comb begin
    case (mode_q)
      3'h3: lo = 2;
      3'h1: lo = tsel_q ? ERASE1_CYC : ERASE0_CYC;
      default: lo = (tsel_q ? WRITE1_CYC : WRITE0_CYC) + 30;
    endcase
  end
  reset_idle_a: assert property ($fell(rst_i) |-> !stall && sfr_rdata == 8'h00)
    else $error("link not idle after reset");
  stall_cause_a: assert property ($rose(stall) |-> $past(ctl_wr))
    else $error("stall without a launching write");
  op_length_a: assert property (
      $fell(stall) |-> len_q >= lo && len_q <= lo + 8)
    else $error("operation length wrong");
  link_quiet_a: assert property (stall |-> !(sfr_we || sfr_re))
    else $error("register access while stalled");
  rdata_hold_a: assert property (!sfr_re |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  aux_zero_a: assert property (
      sfr_re && sfr_addr == 4'h1 |=> sfr_rdata[7:2] == 6'h00)
    else $error("unused aux bits not zero");
  sw_enable_a: assert property (
      sfr_re && sfr_addr == 4'h0 && !armed_q |=> !sfr_rdata[7])
    else $error("enabled flag set without unlock");
  trigger_clear_a: assert property (
      sfr_re && sfr_addr == 4'h0 && age_q > UNLOCK_CYC + 2
      |=> !sfr_rdata[3])
    else $error("trigger not cleared after window");
  initiate_clear_a: assert property (
      sfr_re && sfr_addr == 4'h0 |=> !sfr_rdata[2] && !sfr_rdata[0])
    else $error("initiate bit left set");
endmodule

/* verification/tb_flash_iap_sequencer.sv */
// self-checking bench: cpu end and sequencer joined over the register link
`timescale 1ns/10ps
module tb_flash_iap_sequencer;
  localparam int E0 = 20, W0 = 15, E1 = 30, W1 = 25, UNL = 100;
  logic        clk_i, rst_i, cyc, stb, we, ack, f_er, f_we, f_rd;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [13:0] f_addr, er_addr;
  logic [15:0] f_wd, f_rdat, w, v;
  logic [15:0] mem [16384];
  logic [19:0] rows [5];
  int          miscompares, num_checks, cycles, n_er, n_we, n_rd, hold;
  fiap_if sfr ();
  fiap_cpu i_fiap_cpu (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sfr(sfr));
  fiap_seq #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1),
    .WRITE1_CYC(W1), .UNLOCK_CYC(UNL)) i_fiap_seq (.clk_i(clk_i),
    .rst_i(rst_i), .sfr(sfr), .flash_erase_o(f_er), .flash_we_o(f_we),
    .flash_rd_o(f_rd), .flash_addr_o(f_addr), .flash_wdata_o(f_wd),
    .flash_rdata_i(f_rdat));
  fiap_link_asserts #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1),
    .WRITE1_CYC(W1), .UNLOCK_CYC(UNL)) i_asserts (.clk_i(clk_i),
    .rst_i(rst_i), .sfr_we(sfr.sfr_we), .sfr_re(sfr.sfr_re),
    .sfr_addr(sfr.sfr_addr), .sfr_wdata(sfr.sfr_wdata),
    .sfr_rdata(sfr.sfr_rdata), .stall(sfr.stall));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // flash array stand-in; read data turns over once its hold has run out
  always @(posedge clk_i) begin
    hold <= f_rd ? 6 : hold - int'(hold != 0);
    if (f_rd) f_rdat <= mem[f_addr];
    else if (hold == 1) f_rdat <= ~f_rdat;
    if (f_we) mem[f_addr] <= f_wd;
    if (f_er) er_addr <= f_addr;
    if (f_er) begin
      for (int i = 0; i < 32; i++) mem[{f_addr[13:5], 5'(i)}] <= 16'h0000;
    end
    n_we += int'(f_we);
    n_er += int'(f_er);
    n_rd += int'(f_rd);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    // no timeout of its own; ack or the cycle ceiling ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic poll();
    do begin
      wb(1'b0, 4'h4, 32'h0);
    end while (q[0] !== 1'b0);
  endtask
  task automatic put(input logic [3:0] off, input logic [7:0] d);
    poll();
    wb(1'b1, 4'h0, {20'h00000, off, d});
  endtask
  task automatic get(input logic [3:0] off);
    poll();
    wb(1'b1, 4'h0, {15'h0000, 1'b1, 4'h0, off, 8'h00});
    poll();
    v = {8'h00, q[15:8]};
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ld(input logic [15:0] d);
    put(4'h4, d[7:0]);
    put(4'h5, d[15:8]);
  endtask
  task automatic rdw(input logic [13:0] a);
    logic [7:0] lo;
    put(4'h0, 8'h32);
    put(4'h2, a[7:0]);
    put(4'h3, {2'b00, a[13:8]});
    put(4'h0, 8'h33);
    get(4'h4);
    lo = v[7:0];
    get(4'h5);
    w = {v[7:0], lo};
  endtask
  // kind 0 correct keys, 1 one wrong key, 2 keys after the window
  task automatic unlock(input int kind);
    logic [7:0] k [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
    if (kind == 1) k[5] = 8'h41;
    put(4'h0, 8'h68);
    if (kind == 2) repeat (UNL + 10) @(posedge clk_i);
    for (int i = 0; i < 6; i++) put(4'(6 + i), k[i]);
    repeat (UNL + 10) @(posedge clk_i);
  endtask
  task automatic done(input string s);
    $display("test %0s finished", s);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, adr, wdat, f_rdat, hold} = '0;
    {miscompares, num_checks, cycles, n_er, n_we, n_rd} = '0;
    sel = 4'hF;
    rst_i = 1'b1;
    for (int i = 0; i < 16384; i++) mem[i] = 16'(i) ^ 16'hA5A5;
    rows = '{20'h2_5A_5A, 20'h3_FF_3F, 20'h1_FE_02, 20'h4_77_77, 20'h0_80_00};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    get(4'h0);
    chk(v, 16'h0000);
    foreach (rows[i]) begin
      put(rows[i][19:16], rows[i][15:8]);
      get(rows[i][19:16]);
      chk(v, {8'h00, rows[i][7:0]});
    end
    wb(1'b0, 4'h8, 32'h0);
    chk(q[15:0] | q[31:16], 16'h0000);
    done("registers");
    for (int k = 1; k < 3; k++) begin
      unlock(k);
      get(4'h0);
      chk(v, 16'h0060);
    end
    put(4'h0, 8'h14);
    unlock(0);
    get(4'h0);
    chk(v, 16'h00E0);
    put(4'h0, 8'h00);
    put(4'h0, 8'h14);
    get(4'h0);
    chk(v, 16'h0010);
    chk(16'(n_er), 16'h0000);
    done("unlock");
    unlock(0);
    put(4'h2, 8'h40);
    put(4'h3, 8'h01);
    put(4'h5, 8'h00);
    put(4'h5, 8'h00);
    put(4'h0, 8'h94);
    poll();
    chk(16'(n_er), 16'h0001);
    chk({2'b00, er_addr}, 16'h0140);
    get(4'h0);
    chk(v, 16'h0090);
    put(4'h0, 8'h80);
    put(4'h2, 8'h5E);
    ld(16'h1111);
    ld(16'h2222);
    ld(16'h3333);
    put(4'h0, 8'h84);
    poll();
    chk(16'(n_we), 16'h0002);
    // short timing for the repeat write, so both selections are timed
    put(4'h1, 8'h01);
    for (int n = 0; n < 20; n++) if (n == 0 || v[0] !== 1'b0) get(4'h1);
    chk(v, 16'h0000);
    put(4'h2, 8'h45);
    ld(16'h4444);
    put(4'h0, 8'h84);
    poll();
    chk(16'(n_we), 16'h0003);
    done("erase and write");
    rdw(14'h015E);
    chk(w, 16'h1111);
    rdw(14'h015F);
    chk(w, 16'h3333);
    rdw(14'h0145);
    chk(w, 16'h4444);
    rdw(14'h014A);
    chk(w, 16'h0000);
    rdw(14'h0160);
    chk(w, 16'h0160 ^ 16'hA5A5);
    put(4'h0, 8'h00);
    put(4'h0, 8'h31);
    chk(16'(n_rd), 16'h0005);
    done("read");
    stop_test();
  end
endmodule
